// [design/bus_addr_decode.v]
// Address steering decoder: on chip or off chip target
`default_nettype none
module bus_addr_decode (
  input  wire [15:0] addr_in,    // Access address
  input  wire        fetch_in,   // Instruction fetch
  input  wire        ea_in,      // Synchronised external access select
  output wire [2:0]  target_out  // Target code
);
`include "ext_bus_map.vh"

  // Classify one address
  function [2:0] classify;
    input [15:0] a;
    input        f;
    input        ea;
    begin
      if (f && a <= `RAM_TOP) begin
        classify = `TGT_EXT;
      end else if (a <= `SFR_TOP) begin
        classify = `TGT_SFR;
      end else if (a <= `RAM_TOP) begin
        classify = `TGT_RAM;
      end else if (a < `PORT_BASE) begin
        classify = `TGT_EXT;                 // Low external memory
      end else if (a < `ROM_BASE) begin
        classify = `TGT_PORT;                // Port 3 and 4 pair
      end else if (a <= `ROM_TOP) begin
        classify = ea ? `TGT_ROM : `TGT_EXT;
      end else begin
        classify = `TGT_EXT;
      end
    end
  endfunction

  // Pure combinational classification
  assign target_out = classify(addr_in, fetch_in, ea_in);
endmodule // bus_addr_decode
`default_nettype wire

// [design/ext_bus_interface.v]
// External bus interface with AXI4-Lite control registers
//
// The address map and the AXI4-Lite interface to the registers were left to the implementer.
`default_nettype none
module ext_bus_interface (
  input  wire        mclk_in,             // Core clock
  input  wire        reset_in,            // Sync reset, high
  // AXI4-Lite slave
  input  wire [7:0]  s_axi_awaddr_in,     // Write address
  input  wire        s_axi_awvalid_in,    // Write address valid
  output reg         s_axi_awready_out,   // Write address ready
  input  wire [31:0] s_axi_wdata_in,      // Write data
  input  wire [3:0]  s_axi_wstrb_in,      // Byte enables
  input  wire        s_axi_wvalid_in,     // Write data valid
  output reg         s_axi_wready_out,    // Write data ready
  output reg  [1:0]  s_axi_bresp_out,     // Write response
  output reg         s_axi_bvalid_out,    // Write response valid
  input  wire        s_axi_bready_in,     // Write response ready
  input  wire [7:0]  s_axi_araddr_in,     // Read address
  input  wire        s_axi_arvalid_in,    // Read address valid
  output reg         s_axi_arready_out,   // Read address ready
  output reg  [31:0] s_axi_rdata_out,     // Read data
  output reg  [1:0]  s_axi_rresp_out,     // Read response
  output reg         s_axi_rvalid_out,    // Read data valid
  input  wire        s_axi_rready_in,     // Read data ready
  // Core access port
  input  wire        req_valid_in,        // Access request
  output reg         req_ready_out,       // Request accepted
  input  wire [15:0] req_addr_in,         // Access address
  input  wire        req_write_in,        // Write access
  input  wire        req_word_in,         // Word, else byte
  input  wire        req_fetch_in,        // Instruction fetch
  input  wire [15:0] req_wdata_in,        // Write data
  output reg         rsp_valid_out,       // Access finished pulse
  output reg  [2:0]  rsp_target_out,      // Where it went
  output reg  [15:0] rsp_rdata_out,       // External read data
  // External pins
  output reg  [15:0] ext_addr_out,        // Address bus
  output reg  [15:0] ext_data_out,        // Data bus drive
  output reg         ext_data_oe_out,     // Data bus enable
  input  wire [15:0] ext_data_in,         // Data bus level
  output reg         read_strobe_n_out,   // Read strobe, low
  output reg         write_low_strobe_n_out, // Write or low write, low
  output reg         high_byte_enable_n_out, // High enable or write, low
  output reg         address_valid_strobe_out, // Latch or valid
  output reg         fetch_indicator_out, // Fetch cycle
  output reg         divided_clock_out,   // Half rate clock
  input  wire        ready_in,            // Cycle ready
  input  wire        bus_width_in,        // High for 16-bit
  input  wire        external_access_select_in, // On chip select
  input  wire        nmi_in,              // Non-maskable request
  output reg         nmi_req_out,         // NMI taken pulse
  output reg  [15:0] nmi_vector_out       // NMI vector address
);
`include "ext_bus_map.vh"

  // One-hot bus states
  localparam [4:0] ST_IDLE = 5'b00001;
  localparam [4:0] ST_ADDR = 5'b00010;
  localparam [4:0] ST_STRB = 5'b00100;
  localparam [4:0] ST_WAIT = 5'b01000;
  localparam [4:0] ST_DONE = 5'b10000;

  reg  [4:0]  state;       // Bus state
  reg  [31:0] config_reg;  // Software config
  reg  [15:0] wait_count;  // Total wait phases
  reg  [15:0] cycle_count; // External accesses done
  reg  [2:0]  last_target; // Last access target
  reg  [15:0] cur_addr;    // Current byte address
  reg  [15:0] cur_wdata;   // Write data held
  reg         cur_write;   // Write cycle
  reg         cur_word;    // Word cycle
  reg         byte_idx;    // Second byte of split word
  reg         width16;     // Current cycle width
  reg  [15:0] acc_rdata;   // Read data gathered
  // Input synchronisers
  reg  [15:0] data_s1;     // Data first stage
  reg  [15:0] data_s2;     // Data second stage
  reg  [3:0]  ctl_s1;      // Control first stage
  reg  [3:0]  ctl_s2;      // Control second stage
  reg         nmi_s3;      // NMI edge history
  // AXI holding state
  reg         aw_got;      // Write address held
  reg         w_got;       // Write data held
  reg  [7:0]  aw_addr;     // Held write address
  reg  [31:0] w_data;      // Held write data
  reg  [3:0]  w_strb;      // Held byte enables
  reg  [31:0] next_rdata;  // Read mux result
  reg         next_rerr;   // Read mux error

  wire ready_s   = ctl_s2[0];
  wire width_s   = ctl_s2[1];
  wire ea_s      = ctl_s2[2];
  wire nmi_s     = ctl_s2[3];
  wire cfg_dyn   = config_reg[`CFG_DYN_WIDTH];
  wire cfg_split = config_reg[`CFG_WR_SPLIT];
  wire cfg_adv   = config_reg[`CFG_ADV_MODE];
  wire phase_en  = divided_clock_out;       // One pulse per half rate period
  wire req_fire  = req_valid_in && req_ready_out;
  wire new_w16   = cfg_dyn && width_s;
  wire lane_hi   = new_w16 ? (cur_word || cur_addr[0]) : cur_addr[0];
  wire lane_lo   = new_w16 ? (cur_word || !cur_addr[0]) : !cur_addr[0];
  wire need_hi   = cur_word && !width16 && !byte_idx;
  wire [7:0] low_byte = (cur_word && byte_idx) ? cur_wdata[15:8] : cur_wdata[7:0];
  wire [2:0] dec_target; // Decoded target of request

  // Address classification ahead of any strobe
  bus_addr_decode u_decode (
    .addr_in    (req_addr_in),
    .fetch_in   (req_fetch_in),
    .ea_in      (ea_s),
    .target_out (dec_target)
  );

  // Two-stage synchronisers for pin inputs
  always @(posedge mclk_in) begin
    if (reset_in) begin
      data_s1 <= 16'h0000;
      data_s2 <= 16'h0000;
      ctl_s1  <= 4'h0;
      ctl_s2  <= 4'h0;
      nmi_s3  <= 1'b0;
    end else begin
      data_s1 <= ext_data_in;
      data_s2 <= data_s1;
      ctl_s1  <= {nmi_in, external_access_select_in, bus_width_in, ready_in};
      ctl_s2  <= ctl_s1;
      nmi_s3  <= nmi_s;
    end
  end

  // Half rate clock out and NMI edge detect
  always @(posedge mclk_in) begin
    if (reset_in) begin
      divided_clock_out <= 1'b0;
      nmi_req_out       <= 1'b0;
      nmi_vector_out    <= `NMI_VECTOR;
    end else begin
      divided_clock_out <= !divided_clock_out;
      nmi_req_out       <= nmi_s && !nmi_s3;
      nmi_vector_out    <= `NMI_VECTOR;
    end
  end

  // Bus cycle sequencer
  always @(posedge mclk_in) begin
    if (reset_in) begin
      state                    <= ST_IDLE;
      req_ready_out            <= 1'b1;
      rsp_valid_out            <= 1'b0;
      rsp_target_out           <= `TGT_SFR;
      rsp_rdata_out            <= 16'h0000;
      ext_addr_out             <= 16'h0000;
      ext_data_out             <= 16'h0000;
      ext_data_oe_out          <= 1'b0;
      read_strobe_n_out        <= 1'b1;
      write_low_strobe_n_out   <= 1'b1;
      high_byte_enable_n_out   <= 1'b1;
      address_valid_strobe_out <= 1'b0;
      fetch_indicator_out      <= 1'b0;
      cur_addr                 <= 16'h0000;
      cur_wdata                <= 16'h0000;
      cur_write                <= 1'b0;
      cur_word                 <= 1'b0;
      byte_idx                 <= 1'b0;
      width16                  <= 1'b0;
      acc_rdata                <= 16'h0000;
      wait_count               <= 16'h0000;
      cycle_count              <= 16'h0000;
      last_target              <= `TGT_SFR;
    end else begin
      rsp_valid_out <= 1'b0;
      case (state)
        ST_IDLE: begin
          // Address strobe rests inactive for its form
          address_valid_strobe_out <= cfg_adv;
          if (req_fire) begin
            rsp_target_out <= dec_target;
            last_target    <= dec_target;
            if (dec_target == `TGT_EXT) begin
              req_ready_out       <= 1'b0;
              cur_addr            <= req_addr_in;
              cur_wdata           <= req_wdata_in;
              cur_write           <= req_write_in;
              cur_word            <= req_word_in;
              byte_idx            <= 1'b0;
              acc_rdata           <= 16'h0000;
              ext_addr_out        <= req_addr_in;
              fetch_indicator_out <= req_fetch_in && !req_write_in;
              address_valid_strobe_out <= !cfg_adv;
              state               <= ST_ADDR;
            end else begin
              // Internal target answers at once, no strobes
              rsp_valid_out <= 1'b1;
              rsp_rdata_out <= 16'h0000;
            end
          end
        end
        ST_ADDR: begin
          if (phase_en) begin
            width16 <= new_w16;
            if (!cfg_adv) begin
              address_valid_strobe_out <= 1'b0;
            end
            if (cur_write) begin
              ext_data_oe_out <= 1'b1;
              if (new_w16 && cur_word) begin
                ext_data_out <= cur_wdata;
              end else if (new_w16 && cur_addr[0]) begin
                ext_data_out <= {cur_wdata[7:0], 8'h00};
              end else begin
                ext_data_out <= {8'h00, low_byte};
              end
              write_low_strobe_n_out <= cfg_split ? !lane_lo : 1'b0;
              high_byte_enable_n_out <= !lane_hi;
            end else begin
              read_strobe_n_out <= 1'b0;
            end
            state <= ST_STRB;
          end
        end
        ST_STRB: begin
          if (phase_en) begin
            state <= ST_WAIT;
          end
        end
        ST_WAIT: begin
          if (phase_en) begin
            if (ready_s) begin
              if (!cur_write) begin
                if (width16 && cur_word) begin
                  acc_rdata <= data_s2;
                end else if (width16 && cur_addr[0]) begin
                  acc_rdata <= {8'h00, data_s2[15:8]};
                end else if (byte_idx) begin
                  acc_rdata <= {data_s2[7:0], acc_rdata[7:0]};
                end else begin
                  acc_rdata <= {8'h00, data_s2[7:0]};
                end
              end
              read_strobe_n_out      <= 1'b1;
              write_low_strobe_n_out <= 1'b1;
              high_byte_enable_n_out <= 1'b1;
              ext_data_oe_out        <= 1'b0;
              if (cfg_adv) begin
                address_valid_strobe_out <= 1'b1;
              end
              state <= ST_DONE;
            end else begin
              wait_count <= wait_count + 16'h0001;
            end
          end
        end
        ST_DONE: begin
          if (phase_en) begin
            if (need_hi) begin
              // Second byte of a word on the narrow bus
              byte_idx     <= 1'b1;
              cur_addr     <= cur_addr + 16'h0001;
              ext_addr_out <= cur_addr + 16'h0001;
              address_valid_strobe_out <= !cfg_adv;
              state        <= ST_ADDR;
            end else begin
              rsp_valid_out       <= 1'b1;
              rsp_rdata_out       <= acc_rdata;
              req_ready_out       <= 1'b1;
              fetch_indicator_out <= 1'b0;
              cycle_count         <= cycle_count + 16'h0001;
              state               <= ST_IDLE;
            end
          end
        end
        default: begin
          state         <= ST_IDLE;
          req_ready_out <= 1'b1;
        end
      endcase
    end
  end

  // AXI write channel and config register
  always @(posedge mclk_in) begin
    if (reset_in) begin
      s_axi_awready_out <= 1'b1;
      s_axi_wready_out  <= 1'b1;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `RESP_OKAY;
      aw_got            <= 1'b0;
      w_got             <= 1'b0;
      aw_addr           <= 8'h00;
      w_data            <= 32'h00000000;
      w_strb            <= 4'h0;
      config_reg        <= `CFG_RESET;
    end else begin
      if (s_axi_awvalid_in && s_axi_awready_out) begin
        aw_got            <= 1'b1;
        aw_addr           <= s_axi_awaddr_in;
        s_axi_awready_out <= 1'b0;
      end
      if (s_axi_wvalid_in && s_axi_wready_out) begin
        w_got            <= 1'b1;
        w_data           <= s_axi_wdata_in;
        w_strb           <= s_axi_wstrb_in;
        s_axi_wready_out <= 1'b0;
      end
      if (aw_got && w_got && !s_axi_bvalid_out) begin
        aw_got           <= 1'b0;
        w_got            <= 1'b0;
        s_axi_bvalid_out <= 1'b1;
        if (aw_addr[7:2] == `REG_CONFIG >> 2) begin
          s_axi_bresp_out <= `RESP_OKAY;
          if (w_strb[0]) begin
            config_reg[7:0] <= w_data[7:0] & 8'h0E;
          end
        end else if (aw_addr[7:2] == `REG_STATUS >> 2 || aw_addr[7:2] == `REG_WAITS >> 2) begin
          s_axi_bresp_out <= `RESP_OKAY; // Read-only, write ignored
        end else begin
          s_axi_bresp_out <= `RESP_SLVERR;
        end
      end
      if (s_axi_bvalid_out && s_axi_bready_in) begin
        s_axi_bvalid_out  <= 1'b0;
        s_axi_awready_out <= 1'b1;
        s_axi_wready_out  <= 1'b1;
      end
    end
  end

  // Register read mux
  always @* begin
    next_rdata = 32'h00000000;
    next_rerr  = 1'b0;
    case (s_axi_araddr_in[7:2])
      `REG_CONFIG >> 2: next_rdata = config_reg;
      `REG_STATUS >> 2: begin
        next_rdata[`STS_BUSY]                  = !state[0];
        next_rdata[`STS_TGT_LO+2:`STS_TGT_LO]  = last_target;
        next_rdata[`STS_WIDTH16]               = width16;
        next_rdata[`STS_CNT_LO+15:`STS_CNT_LO] = cycle_count;
      end
      `REG_WAITS >> 2: next_rdata[15:0] = wait_count;
      default: next_rerr = 1'b1;
    endcase
  end

  // AXI read channel
  always @(posedge mclk_in) begin
    if (reset_in) begin
      s_axi_arready_out <= 1'b1;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h00000000;
      s_axi_rresp_out   <= `RESP_OKAY;
    end else begin
      if (s_axi_arvalid_in && s_axi_arready_out) begin
        s_axi_arready_out <= 1'b0;
        s_axi_rvalid_out  <= 1'b1;
        s_axi_rdata_out   <= next_rdata;
        s_axi_rresp_out   <= next_rerr ? `RESP_SLVERR : `RESP_OKAY;
      end
      if (s_axi_rvalid_out && s_axi_rready_in) begin
        s_axi_rvalid_out  <= 1'b0;
        s_axi_arready_out <= 1'b1;
      end
    end
  end
endmodule // ext_bus_interface
`default_nettype wire

// [design/ext_bus_map.vh]
// Constants for the external bus interface and address steering
`ifndef EXT_BUS_MAP_VH
`define EXT_BUS_MAP_VH
// Register byte offsets
`define REG_CONFIG      8'h00
`define REG_STATUS      8'h04
`define REG_WAITS       8'h08
// Config field positions
`define CFG_DYN_WIDTH   1
`define CFG_WR_SPLIT    2
`define CFG_ADV_MODE    3
`define CFG_RESET       32'h00000000
// Status field positions
`define STS_BUSY        0
`define STS_TGT_LO      4
`define STS_WIDTH16     8
`define STS_CNT_LO      16
// AXI responses
`define RESP_OKAY       2'b00
`define RESP_SLVERR     2'b10
// Address map boundaries
`define SFR_TOP         16'h0017
`define RAM_TOP         16'h03FF
`define PORT_BASE       16'h1FFE
`define ROM_BASE        16'h2000
`define ROM_TOP         16'h9FFF
// Access target codes
`define TGT_SFR         3'h0
`define TGT_RAM         3'h1
`define TGT_ROM         3'h2
`define TGT_PORT        3'h3
`define TGT_EXT         3'h4
// Non-maskable interrupt vector
`define NMI_VECTOR      16'h203E
`endif

// [test/ext_bus_interface_monitor.sv]
// Concurrent checks on the external bus interface ports
`default_nettype none
module ext_bus_monitor (
  input wire logic        mclk_in,                // Core clock
  input wire logic        reset_in,               // Sync reset
  input wire logic        req_valid_in,           // Access request
  input wire logic        req_ready_out,          // Request taken
  input wire logic [15:0] req_addr_in,            // Access address
  input wire logic        req_fetch_in,           // Fetch flag
  input wire logic        rsp_valid_out,          // Access done
  input wire logic        read_strobe_n_out,      // Read strobe
  input wire logic        write_low_strobe_n_out, // Write strobe
  input wire logic        high_byte_enable_n_out, // High strobe
  input wire logic        fetch_indicator_out,    // Fetch marker
  input wire logic        divided_clock_out,      // Half clock
  input wire logic        nmi_in,                 // NMI pin
  input wire logic        nmi_req_out,            // NMI taken
  input wire logic [15:0] nmi_vector_out          // NMI vector
);
  default clocking cb @(posedge mclk_in); endclocking
  default disable iff (reset_in);
  logic last_fetch; // Kind of the last accepted access
  // Remember whether the running access is a fetch
  always @(posedge mclk_in) begin
    if (reset_in) last_fetch <= 1'b0;
    else if (req_valid_in && req_ready_out) last_fetch <= req_fetch_in;
  end
  sequence low_data_acc;
    req_valid_in && req_ready_out && !req_fetch_in && req_addr_in <= 16'h03FF;
  endsequence
  sequence rd_start;
    $fell(read_strobe_n_out);
  endsequence
  chk_low_internal: assert property (
    low_data_acc |=> rsp_valid_out && read_strobe_n_out && write_low_strobe_n_out)
    else $error("low data access made a bus cycle");
  chk_rd_ext_only: assert property (
    !read_strobe_n_out |-> !req_ready_out) else $error("read strobe while idle");
  chk_wr_ext_only: assert property (
    !(write_low_strobe_n_out && high_byte_enable_n_out) |-> !req_ready_out && read_strobe_n_out)
    else $error("write strobe outside a write cycle");
  chk_fetch_mark: assert property (
    rd_start |-> fetch_indicator_out == last_fetch) else $error("fetch marker wrong");
  chk_fetch_ext: assert property (
    fetch_indicator_out |-> !req_ready_out) else $error("fetch marker while idle");
  chk_cycle_ends: assert property (
    rd_start |-> ##[4:200] rsp_valid_out) else $error("bus cycle never ended");
  chk_half_clock: assert property (
    !$past(reset_in) |-> divided_clock_out != $past(divided_clock_out)) else $error("clock out stuck");
  chk_nmi_edge: assert property (
    $rose(nmi_in) |-> ##[1:5] nmi_req_out) else $error("nmi edge not taken");
  chk_nmi_vector: assert property (
    nmi_req_out |-> nmi_vector_out == 16'h203E) else $error("nmi vector wrong");
endmodule // ext_bus_monitor
bind ext_bus_interface ext_bus_monitor mon (.*);
`default_nettype wire

// [test/ext_mem_model.sv]
// Memory-side model: read data pattern and ready stretching
`default_nettype none
module ext_mem_model (
  input  wire logic        mclk_in,  // Core clock
  input  wire logic        reset_in, // Sync reset
  input  wire logic        rd_n,     // Read strobe
  input  wire logic        wl_n,     // Low write strobe
  input  wire logic        bh_n,     // High strobe
  input  wire logic [15:0] addr,     // Address bus
  input  wire logic [3:0]  waits,    // Cycles to hold ready low
  output logic      [15:0] data,     // Read data to pins
  output logic             ready     // Ready pin
);
  logic [3:0] cnt; // Cycles into the strobe
  // Ready and data follow the strobes, junk between cycles
  always @(posedge mclk_in) begin
    if (reset_in) begin
      cnt   <= 4'h0;
      ready <= 1'b0;
      data  <= 16'h0000;
    end else begin
      if (rd_n && wl_n && bh_n) begin
        cnt   <= 4'h0;
        ready <= (waits == 4'h0) ? ~ready : 1'b0;
      end else begin
        if (cnt != 4'hF) cnt <= cnt + 4'h1;
        ready <= (cnt >= waits);
      end
      data <= rd_n ? ~data : {~addr[7:0], addr[7:0]};
    end
  end
endmodule // ext_mem_model
`default_nettype wire

// [test/tb_ext_bus_interface.sv]
// Testbench for the external bus interface
`default_nettype none
module tb_ext_bus_interface;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_in = 1'b0, reset_in = 1'b1;
  logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00;
  logic [31:0] s_axi_wdata_in = 32'h0, s_axi_rdata_out, rd_data;
  logic [3:0] s_axi_wstrb_in = 4'hF, waits = 4'h0;
  logic s_axi_awvalid_in = 1'b0, s_axi_wvalid_in = 1'b0, s_axi_bready_in = 1'b0;
  logic s_axi_arvalid_in = 1'b0, s_axi_rready_in = 1'b0;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [1:0] s_axi_bresp_out, s_axi_rresp_out, rd_resp;
  logic req_valid_in = 1'b0, req_write_in = 1'b0, req_word_in = 1'b0, req_fetch_in = 1'b0;
  logic req_ready_out, rsp_valid_out, ext_data_oe_out, read_strobe_n_out;
  logic [15:0] req_addr_in = 16'h0, req_wdata_in = 16'h0, rsp_rdata_out, ext_addr_out;
  logic [15:0] ext_data_out, ext_data_in, nmi_vector_out, rdv, wdv;
  logic [2:0] rsp_target_out, tgt;
  logic write_low_strobe_n_out, high_byte_enable_n_out, address_valid_strobe_out;
  logic fetch_indicator_out, divided_clock_out, ready_in, nmi_req_out;
  logic bus_width_in = 1'b0, external_access_select_in = 1'b1, nmi_in = 1'b0;
  int failures = 0, num_checks = 0, cyc = 0, nrd, nwl, nbh, nas, fi, dur;
  ext_bus_interface dut (.*);
  ext_mem_model mem (.mclk_in(mclk_in), .reset_in(reset_in), .rd_n(read_strobe_n_out),
    .wl_n(write_low_strobe_n_out), .bh_n(high_byte_enable_n_out), .addr(ext_addr_out),
    .waits(waits), .data(ext_data_in), .ready(ready_in));
  // 125 MHz core clock
  initial forever #4 mclk_in = ~mclk_in;
  // Cut a hang short
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      end_sim();
    end
  end
  task end_sim;
    if (failures == 0 && num_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Register write, address and data offered together
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    s_axi_awaddr_in <= a;
    s_axi_wdata_in <= d;
    s_axi_awvalid_in <= 1'b1;
    s_axi_wvalid_in <= 1'b1;
    s_axi_bready_in <= 1'b1;
    forever begin
      @(posedge mclk_in);
      if (s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_bvalid_out === 1'b1) break;
    end
    s_axi_bready_in <= 1'b0;
    chk(s_axi_bresp_out, 2'b00, "bresp");
    @(posedge mclk_in);
  endtask
  // Register read
  task automatic axi_rd(input logic [7:0] a);
    s_axi_araddr_in <= a;
    s_axi_arvalid_in <= 1'b1;
    s_axi_rready_in <= 1'b1;
    forever begin
      @(posedge mclk_in);
      if (s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
      if (s_axi_rvalid_out === 1'b1) break;
    end
    rd_data = s_axi_rdata_out;
    rd_resp = s_axi_rresp_out;
    s_axi_rready_in <= 1'b0;
    @(posedge mclk_in);
  endtask
  // One core access; counts strobe activity until done
  task automatic acc(input logic [15:0] a, input logic w, wd, f);
    logic prd, pwl, pbh, pas;
    req_addr_in <= a;
    req_write_in <= w;
    req_word_in <= wd;
    req_fetch_in <= f;
    req_wdata_in <= 16'hC35A;
    req_valid_in <= 1'b1;
    {nrd, nwl, nbh, nas, fi, dur, wdv} = '0;
    do @(posedge mclk_in); while (req_ready_out !== 1'b1);
    req_valid_in <= 1'b0;
    {prd, pwl, pbh, pas} = {3'b111, address_valid_strobe_out};
    while (rsp_valid_out !== 1'b1 && dur < 400) begin
      @(posedge mclk_in);
      dur++;
      if (!read_strobe_n_out && prd) nrd++;
      if (!write_low_strobe_n_out && pwl) nwl++;
      if (!high_byte_enable_n_out && pbh) nbh++;
      if (address_valid_strobe_out !== pas) nas++;
      if (!read_strobe_n_out && fetch_indicator_out) fi = 1;
      if (!(write_low_strobe_n_out && high_byte_enable_n_out)) wdv = ext_data_out;
      {prd, pwl, pbh, pas} = {read_strobe_n_out, write_low_strobe_n_out,
                              high_byte_enable_n_out, address_valid_strobe_out};
    end
    tgt = rsp_target_out;
    rdv = rsp_rdata_out;
  endtask
  task t_regs;
    axi_rd(8'h00);
    chk(rd_data, 32'h0, "config reset");
    axi_rd(8'h0C);
    chk(rd_resp, 2'b10, "unmapped resp");
    axi_wr(8'h00, 32'h0000000E);
    axi_rd(8'h00);
    chk(rd_data, 32'h0000000E, "config back");
    axi_wr(8'h00, 32'h0);
  endtask
  task automatic t_internal;
    logic [15:0] ad [4] = '{16'h0000, 16'h0017, 16'h0018, 16'h03FF};
    for (int i = 0; i < 4; i++) begin
      acc(ad[i], i[0], 1'b0, 1'b0);
      chk(tgt, (i < 2) ? 3'h0 : 3'h1, "target");
      chk(nrd + nwl + nbh + nas, 0, "strobes");
      chk(dur < 3, 1, "internal time");
    end
  endtask
  task t_fetch;
    acc(16'h0010, 1'b0, 1'b0, 1'b1);
    chk(tgt, 3'h4, "fetch target");
    chk(nrd, 1, "fetch reads");
    chk(fi, 1, "fetch marks");
    chk(rdv[7:0], 8'h10, "fetch data");
    acc(16'h03FF, 1'b0, 1'b0, 1'b1);
    chk(tgt, 3'h4, "fetch top");
  endtask
  task automatic t_ea;
    logic [15:0] ad [4] = '{16'h2000, 16'h9FFF, 16'hA000, 16'hFFFF};
    logic ex;
    for (int e = 1; e >= 0; e--) begin
      external_access_select_in <= e[0];
      repeat (4) @(posedge mclk_in);
      for (int i = 0; i < 4; i++) begin
        ex = (e == 0) || (i > 1);
        acc(ad[i], 1'b0, 1'b0, 1'b0);
        chk(tgt, ex ? 3'h4 : 3'h2, "ea target");
        chk(nrd, ex, "ea read");
        chk(fi, 0, "ea fetch");
      end
    end
    external_access_select_in <= 1'b1;
  endtask
  task automatic t_width;
    // Fields: config, width pin, address, read strobes, read data
    logic [43:0] tb [4] = '{44'h21A0001FF00, 44'h20A00420504, 44'h01A00420504, 44'hA1A0001FF00};
    for (int i = 0; i < 4; i++) begin
      axi_wr(8'h00, {28'h0, tb[i][43:40]});
      bus_width_in <= tb[i][36];
      repeat (4) @(posedge mclk_in);
      acc(tb[i][35:20], 1'b0, 1'b1, 1'b0);
      chk(nrd, tb[i][19:16], "byte cycles");
      chk(rdv, tb[i][15:0], "word data");
      chk(nas, 2 * tb[i][19:16], "addr strobe");
      chk(address_valid_strobe_out, tb[i][43], "strobe idle");
    end
  endtask
  task automatic t_wstrobe;
    // Fields: config, address, word flag then low and high strobe counts
    logic [23:0] tw [6] = '{24'h2A0022, 24'h2A0033, 24'h2A004B, 24'h6A0022, 24'h6A0031, 24'h6A004B};
    bus_width_in <= 1'b1;
    for (int i = 0; i < 6; i++) begin
      axi_wr(8'h00, {28'h0, tw[i][23:20]});
      acc(tw[i][19:4], 1'b1, tw[i][3], 1'b0);
      chk(nwl, tw[i][1], "low write");
      chk(nbh, tw[i][0], "high write");
      chk(nrd, 0, "no read");
      chk(wdv, tw[i][3] ? 16'hC35A : (tw[i][4] ? 16'h5A00 : 16'h005A), "write data");
    end
  endtask
  task t_ready;
    int d0;
    acc(16'hA000, 1'b0, 1'b0, 1'b0);
    d0 = dur;
    waits <= 4'hC;
    acc(16'hA000, 1'b0, 1'b0, 1'b0);
    chk(dur > d0 + 9, 1, "stretch");
    chk(rdv[7:0], 8'h00, "slow data");
    waits <= 4'h0;
  endtask
  task automatic t_misc;
    int n = 0;
    logic p = divided_clock_out;
    repeat (16) begin
      @(posedge mclk_in);
      if (divided_clock_out !== p) n++;
      p = divided_clock_out;
    end
    chk(n, 16, "clock toggles");
    nmi_in <= 1'b1;
    for (int t = 0; t < 8 && nmi_req_out !== 1'b1; t++) @(posedge mclk_in);
    chk(nmi_req_out, 1'b1, "nmi taken");
    chk(nmi_vector_out, 16'h203E, "nmi vector");
    nmi_in <= 1'b0;
  endtask
  // Main sequence
  initial begin
    repeat (12) @(posedge mclk_in);
    reset_in <= 1'b0;
    repeat (4) @(posedge mclk_in);
    t_regs;
    t_internal;
    t_fetch;
    t_ea;
    t_width;
    t_wstrobe;
    t_ready;
    t_misc;
    end_sim;
  end
endmodule // tb_ext_bus_interface
`default_nettype wire
